// *** afescr_host_model.sv ***
/*
 * Host model of the three-wire control port: one 16-bit frame per call.
 * Assumes the caller enters xfer just after a falling clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module afescr_host_model (
    input wire logic clock_in,      // Master clock
    input wire logic sdo_in,        // Readback bit
    input wire logic soe_in,        // Readback driven
    output logic sclk_out = 1'b0,   // Serial clock
    output logic sdata_out = 1'b0,  // Serial data
    output logic sen_out = 1'b0     // Frame enable
);
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {rd, 1'b0, a, d};
        q = 8'h00;
        sen_out = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            sdata_out = f[i];
            repeat (8) @(negedge clock_in);
            if (i < 8) q[i] = (soe_in === 1'b1) ? sdo_in : 1'bx;
            sclk_out = 1'b1;
            repeat (8) @(negedge clock_in);
            sclk_out = 1'b0;
        end
        repeat (8) @(negedge clock_in);
        sen_out = 1'b0;
        // Released line must not keep the last bit
        sdata_out = ~sdata_out;
        repeat (8) @(negedge clock_in);
    endtask
endmodule
`default_nettype wire

// *** afescr_pin_sync.sv ***
/*
 * Three-stage synchroniser for a group of pins; a level is accepted once the
 * second and third stages agree.
 * Assumes the pins are asynchronous to clock_in.
 */
`timescale 1ns/10ps
`default_nettype none
module afescr_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock_in,            // Master clock
    input wire logic rst_in,              // Synchronous reset
    input wire logic ce_in,               // Clock enable
    input wire logic [WIDTH-1:0] pins_in, // Asynchronous pins
    output logic [WIDTH-1:0] level_out    // Accepted levels
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    level_out[i] <= 1'b0;
                end else if (ce_in) begin
                    s1 <= pins_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        level_out[i] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** afescr_pkg.sv ***
/*
 * Shared constants and types for the scanner front-end setup register bank:
 * serial frame layout, register addresses, field positions, reset values and
 * output datapath counts.
 * Assumes one 20 MHz master clock and a host that follows the frame format.
 */
package afescr_pkg;

    // ------------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int HEAD_BITS = 8;
    localparam int FRAME_RD_BIT = 15;
    localparam logic [4:0] HEAD_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h0F;

    // ------------------------------------------------------------------
    // Pin order into the synchroniser
    // ------------------------------------------------------------------
    localparam int PIN_COUNT = 4;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDATA = 1;
    localparam int PIN_SEN = 2;
    localparam int PIN_STROBE = 3;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_SETUP_FIRST = 6'h01;
    localparam logic [5:0] ADDR_SETUP_SECOND = 6'h02;
    localparam logic [5:0] ADDR_LAMP_TEST = 6'h24;
    localparam logic [5:0] ADDR_REVISION = 6'h27;

    // ------------------------------------------------------------------
    // Field positions, first setup register
    // ------------------------------------------------------------------
    localparam int F1_POWER = 0;
    localparam int F1_DOUBLE_SAMPLE = 1;
    localparam int F1_EDGE_DETECT = 3;
    localparam int F1_OFFSET_LO = 4;
    localparam int F1_THIRD_MODE = 6;
    localparam int F1_UNLOCK = 7;
    localparam logic [7:0] F1_WRITE_MASK = 8'hFB;

    // ------------------------------------------------------------------
    // Field positions, second setup register
    // ------------------------------------------------------------------
    localparam int F2_POLARITY = 0;
    localparam int F2_NARROW = 1;
    localparam int F2_INVERT = 2;
    localparam int F2_CLAMP_EXT = 3;
    localparam int F2_CLAMP_EN = 4;
    localparam int F2_LATENCY_LO = 6;
    localparam logic [7:0] F2_WRITE_MASK = 8'hDF;

    // ------------------------------------------------------------------
    // Extended page fields
    // ------------------------------------------------------------------
    localparam logic [7:0] LAMP_WRITE_MASK = 8'h3C;
    localparam int REV_LO = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_SETUP_FIRST = 8'h03;
    localparam logic [7:0] RST_SETUP_SECOND = 8'h00;
    localparam logic [7:0] RST_LAMP_TEST = 8'h00;

    // ------------------------------------------------------------------
    // Amplifier offset codes
    // ------------------------------------------------------------------
    localparam logic [1:0] OFFSET_POS_FS = 2'h2;
    localparam logic [1:0] OFFSET_NEG_FS = 2'h3;

    // ------------------------------------------------------------------
    // Latency and output datapath
    // ------------------------------------------------------------------
    localparam logic [3:0] MCLK_PER_CONV = 4'h2;
    localparam logic [3:0] MCLK_PER_CONV_MODE2 = 4'h3;
    localparam int DLY_DEPTH = 10;
    localparam int WORD_BITS = 16;
    localparam logic [2:0] BEATS_WIDE_LAST = 3'h3;
    localparam logic [2:0] BEATS_NARROW_LAST = 3'h7;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_HEAD = 2'b01,
        SER_BODY = 2'b10,
        SER_DONE = 2'b11
    } afescr_ser_state_t;

    typedef struct packed {
        logic power_on;
        logic double_sample_sel;
        logic strobe_edge_detect_en;
        logic [1:0] amp_offset_sel;
        logic third_timing_mode_sel;
        logic ext_page_unlock;
        logic edge_polarity_sel;
        logic narrow_output_sel;
        logic output_invert;
        logic clamp_ref_external;
        logic clamp_enable;
        logic [1:0] output_latency_sel;
    } afescr_cfg_t;

endpackage

// *** afescr_regs.sv ***
/*
 * Setup register bank of the scanner front end: serial control slave, the two
 * setup registers, the extended page, strobe routing and the digital output
 * path (invert, latency, 4 or 2 bit multiplexing).
 * Assumes serial and strobe pins are slow against the 20 MHz master clock.
 */
`timescale 1ns/10ps
`default_nettype none
module afescr_regs #(
    parameter logic [6:0] REVISION_CODE = 7'h15 // Arbitrary value
) (
    input wire logic clock_in,                  // Master clock, 20 MHz
    input wire logic rst_in,                    // Synchronous reset, high
    input wire logic ce_in,                     // Clock enable, freezes all
    input wire logic ser_clk_in,                // Serial clock pin
    input wire logic ser_data_in,               // Serial data pin
    input wire logic ser_enable_in,             // Serial frame enable pin
    output logic ser_data_out,                  // Readback data
    output logic ser_data_oe_out,               // Readback driven
    input wire logic sample_strobe_pin_in,      // External sample strobe
    input wire logic second_timing_mode_in,     // Second timing mode active
    input wire logic [15:0] conv_data_in,       // Converter word
    input wire logic conv_valid_in,             // Converter word strobe
    output logic timing_strobe_out,             // Strobe to timing control
    output afescr_pkg::afescr_cfg_t cfg_out,    // Decoded configuration
    output logic offset_pos_fs_out,             // Offset to positive scale
    output logic offset_neg_fs_out,             // Offset to negative scale
    output logic clamp_ref_dac_en_out,          // Clamp DAC powered
    output logic clamp_ref_oe_out,              // Clamp reference pin driven
    output logic [3:0] lamp_test_field_out,     // Lamp test field
    output logic [3:0] latency_mclk_out,        // Added latency, master clocks
    output logic [3:0] dout_out,                // Multiplexed output data
    output logic dout_valid_out                 // Output beat valid
);
    import afescr_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] pin_prev;
    logic [PIN_COUNT-1:0] pins_raw;

    assign pins_raw = {sample_strobe_pin_in, ser_enable_in, ser_data_in, ser_clk_in};

    afescr_pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .pins_in(pins_raw),
        .level_out(pin_level)
    );

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_prev <= '0;
        end else if (ce_in) begin
            pin_prev <= pin_level;
        end
    end

    logic sclk_rise;
    logic sen_fall;
    logic strobe_rise;
    logic strobe_fall;
    assign sclk_rise = pin_level[PIN_SCLK] & ~pin_prev[PIN_SCLK];
    assign sen_fall = ~pin_level[PIN_SEN] & pin_prev[PIN_SEN];
    assign strobe_rise = pin_level[PIN_STROBE] & ~pin_prev[PIN_STROBE];
    assign strobe_fall = ~pin_level[PIN_STROBE] & pin_prev[PIN_STROBE];

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] setup_first;
    logic [7:0] setup_second;
    logic [7:0] lamp_test_control;
    logic [7:0] revision_code_reg;
    logic unlocked;

    assign unlocked = setup_first[F1_UNLOCK];
    assign revision_code_reg = {REVISION_CODE, 1'b0};

    function automatic logic [7:0] read_value(input logic [5:0] addr);
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            ADDR_SETUP_FIRST: value = setup_first;
            ADDR_SETUP_SECOND: value = setup_second;
            ADDR_LAMP_TEST: value = unlocked ? lamp_test_control : 8'h00;
            ADDR_REVISION: value = unlocked ? revision_code_reg : 8'h00;
            default: value = 8'h00;
        endcase
        return value;
    endfunction

    // ------------------------------------------------------------------
    // Serial control slave
    // ------------------------------------------------------------------
    afescr_ser_state_t ser_state;
    logic [4:0] bit_count;
    logic [FRAME_BITS-1:0] frame;
    logic [7:0] readback;
    logic [HEAD_BITS-1:0] head_byte;
    logic write_strobe;

    assign head_byte = {frame[HEAD_BITS-2:0], pin_level[PIN_SDATA]};
    assign write_strobe = (ser_state == SER_DONE) & sen_fall & ~frame[FRAME_RD_BIT];

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ser_state <= SER_IDLE;
            bit_count <= 5'h00;
            frame <= '0;
            readback <= 8'h00;
            ser_data_oe_out <= 1'b0;
        end else if (ce_in) begin
            if (!pin_level[PIN_SEN]) begin
                ser_state <= SER_IDLE;
                ser_data_oe_out <= 1'b0;
            end else begin
                case (ser_state)
                    SER_IDLE: begin
                        ser_state <= SER_HEAD;
                        bit_count <= 5'h00;
                    end
                    SER_HEAD: begin
                        if (sclk_rise) begin
                            frame <= {frame[FRAME_BITS-2:0], pin_level[PIN_SDATA]};
                            bit_count <= bit_count + 5'h01;
                            if (bit_count == HEAD_LAST) begin
                                ser_state <= SER_BODY;
                                if (head_byte[HEAD_BITS-1]) begin
                                    readback <= read_value(head_byte[5:0]);
                                    ser_data_oe_out <= 1'b1;
                                end
                            end
                        end
                    end
                    SER_BODY: begin
                        if (sclk_rise) begin
                            frame <= {frame[FRAME_BITS-2:0], pin_level[PIN_SDATA]};
                            bit_count <= bit_count + 5'h01;
                            readback <= {readback[6:0], 1'b0};
                            if (bit_count == FRAME_LAST) begin
                                ser_state <= SER_DONE;
                                ser_data_oe_out <= 1'b0;
                            end
                        end
                    end
                    SER_DONE: ser_state <= SER_DONE;
                    default: ser_state <= SER_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ser_data_out <= 1'b0;
        end else if (ce_in) begin
            ser_data_out <= ser_data_oe_out & readback[7];
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            setup_first <= RST_SETUP_FIRST;
            setup_second <= RST_SETUP_SECOND;
            lamp_test_control <= RST_LAMP_TEST;
        end else if (ce_in && write_strobe) begin
            case (frame[13:8])
                ADDR_SETUP_FIRST: setup_first <= frame[7:0] & F1_WRITE_MASK;
                ADDR_SETUP_SECOND: setup_second <= frame[7:0] & F2_WRITE_MASK;
                ADDR_LAMP_TEST: begin
                    if (unlocked) begin
                        lamp_test_control <= frame[7:0] & LAMP_WRITE_MASK;
                    end
                end
                default: setup_first <= setup_first;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Decoded configuration outputs
    // ------------------------------------------------------------------
    logic [1:0] offset_code;
    logic power_on;
    assign offset_code = setup_first[F1_OFFSET_LO +: 2];
    assign power_on = setup_first[F1_POWER];

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cfg_out <= '0;
            offset_pos_fs_out <= 1'b0;
            offset_neg_fs_out <= 1'b0;
            clamp_ref_dac_en_out <= 1'b0;
            clamp_ref_oe_out <= 1'b0;
            lamp_test_field_out <= 4'h0;
        end else if (ce_in) begin
            cfg_out.power_on <= power_on;
            cfg_out.double_sample_sel <= setup_first[F1_DOUBLE_SAMPLE];
            cfg_out.strobe_edge_detect_en <= setup_first[F1_EDGE_DETECT];
            cfg_out.amp_offset_sel <= offset_code;
            cfg_out.third_timing_mode_sel <= setup_first[F1_THIRD_MODE];
            cfg_out.ext_page_unlock <= unlocked;
            cfg_out.edge_polarity_sel <= setup_second[F2_POLARITY];
            cfg_out.narrow_output_sel <= setup_second[F2_NARROW];
            cfg_out.output_invert <= setup_second[F2_INVERT];
            cfg_out.clamp_ref_external <= setup_second[F2_CLAMP_EXT];
            cfg_out.clamp_enable <= power_on & setup_second[F2_CLAMP_EN];
            cfg_out.output_latency_sel <= setup_second[F2_LATENCY_LO +: 2];
            offset_pos_fs_out <= (offset_code == OFFSET_POS_FS);
            offset_neg_fs_out <= (offset_code == OFFSET_NEG_FS);
            clamp_ref_dac_en_out <= power_on & ~setup_second[F2_CLAMP_EXT];
            clamp_ref_oe_out <= power_on & ~setup_second[F2_CLAMP_EXT];
            lamp_test_field_out <= lamp_test_control[5:2];
        end
    end

    // ------------------------------------------------------------------
    // Sample strobe routing
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            timing_strobe_out <= 1'b0;
        end else if (ce_in) begin
            if (!power_on) begin
                timing_strobe_out <= 1'b0;
            end else if (setup_first[F1_EDGE_DETECT]) begin
                timing_strobe_out <= setup_second[F2_POLARITY] ? strobe_rise
                                                               : strobe_fall;
            end else begin
                timing_strobe_out <= pin_level[PIN_STROBE];
            end
        end
    end

    // ------------------------------------------------------------------
    // Output latency
    // ------------------------------------------------------------------
    logic [3:0] lat_mclk;
    logic [3:0] mclk_per_conv;
    assign mclk_per_conv = second_timing_mode_in ? MCLK_PER_CONV_MODE2 : MCLK_PER_CONV;
    assign lat_mclk = 4'({2'b00, setup_second[F2_LATENCY_LO +: 2]} * mclk_per_conv);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            latency_mclk_out <= 4'h0;
        end else if (ce_in) begin
            latency_mclk_out <= lat_mclk;
        end
    end

    logic [WORD_BITS-1:0] delay_data [0:DLY_DEPTH-1];
    logic [DLY_DEPTH-1:0] delay_valid;

    always_ff @(posedge clock_in) begin
        if (ce_in) begin
            delay_data[0] <= conv_data_in ^ {WORD_BITS{setup_second[F2_INVERT]}};
            for (int k = 1; k < DLY_DEPTH; k++) begin
                delay_data[k] <= delay_data[k-1];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            delay_valid <= '0;
        end else if (ce_in) begin
            delay_valid <= power_on ? {delay_valid[DLY_DEPTH-2:0], conv_valid_in} : '0;
        end
    end

    // ------------------------------------------------------------------
    // Output multiplexing
    // ------------------------------------------------------------------
    logic [WORD_BITS-1:0] tap_data;
    logic tap_valid;
    logic [WORD_BITS-1:0] out_word;
    logic [2:0] beats_left;
    logic narrow;

    assign tap_data = delay_data[lat_mclk];
    assign tap_valid = delay_valid[lat_mclk] & power_on;
    assign narrow = setup_second[F2_NARROW];

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            out_word <= '0;
            beats_left <= 3'h0;
            dout_out <= 4'h0;
            dout_valid_out <= 1'b0;
        end else if (ce_in) begin
            if (tap_valid) begin
                if (narrow) begin
                    dout_out <= {2'b00, tap_data[15:14]};
                    out_word <= {tap_data[13:0], 2'b00};
                    beats_left <= BEATS_NARROW_LAST;
                end else begin
                    dout_out <= tap_data[15:12];
                    out_word <= {tap_data[11:0], 4'h0};
                    beats_left <= BEATS_WIDE_LAST;
                end
                dout_valid_out <= 1'b1;
            end else if (beats_left != 3'h0 && power_on) begin
                if (narrow) begin
                    dout_out <= {2'b00, out_word[15:14]};
                    out_word <= {out_word[13:0], 2'b00};
                end else begin
                    dout_out <= out_word[15:12];
                    out_word <= {out_word[11:0], 4'h0};
                end
                beats_left <= beats_left - 3'h1;
                dout_valid_out <= 1'b1;
            end else begin
                beats_left <= 3'h0;
                dout_out <= 4'h0;
                dout_valid_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** afescr_regs_monitor.sv ***
/*
 * Port checker for the setup register bank: decoded outputs against cfg_out.
 * Assumes a single master clock domain and the package constants.
 */
`timescale 1ns/10ps
`default_nettype none
module afescr_regs_monitor
    import afescr_pkg::*;
(
    input wire logic clock_in,              // Clock
    input wire logic rst_in,                // Reset
    input wire logic second_timing_mode_in, // Mode two
    input wire logic timing_strobe_out,     // Strobe
    input wire afescr_cfg_t cfg_out,        // Config
    input wire logic offset_pos_fs_out,     // Offset pos
    input wire logic offset_neg_fs_out,     // Offset neg
    input wire logic clamp_ref_dac_en_out,  // DAC on
    input wire logic clamp_ref_oe_out,      // Pin driven
    input wire logic [3:0] latency_mclk_out, // Latency
    input wire logic [3:0] dout_out,        // Beat data
    input wire logic dout_valid_out         // Beat valid
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence calm;
        ($stable(cfg_out) && $stable(second_timing_mode_in)) [*2];
    endsequence
    a_offset_pos: assert property (
        calm |-> offset_pos_fs_out == (cfg_out.amp_offset_sel == OFFSET_POS_FS))
        else $error("offset positive output wrong");
    a_offset_neg: assert property (
        calm |-> offset_neg_fs_out == (cfg_out.amp_offset_sel == OFFSET_NEG_FS))
        else $error("offset negative output wrong");
    a_clamp_dac: assert property (
        calm |-> clamp_ref_dac_en_out == (cfg_out.power_on && !cfg_out.clamp_ref_external))
        else $error("clamp dac enable wrong");
    a_clamp_pin: assert property (clamp_ref_oe_out == clamp_ref_dac_en_out)
        else $error("clamp pin drive differs from dac");
    a_clamp_gate: assert property (cfg_out.clamp_enable |-> cfg_out.power_on)
        else $error("clamping on while powered down");
    a_latency_calc: assert property (calm |-> latency_mclk_out ==
        4'(cfg_out.output_latency_sel) * (second_timing_mode_in ? MCLK_PER_CONV_MODE2
        : MCLK_PER_CONV)) else $error("latency in master clocks wrong");
    a_strobe_pulse: assert property (
        calm ##0 (cfg_out.strobe_edge_detect_en && timing_strobe_out) |=> !timing_strobe_out)
        else $error("edge strobe pulse too long");
    a_narrow_beat: assert property (
        calm ##0 (dout_valid_out && cfg_out.narrow_output_sel) |-> dout_out[3:2] == 2'h0)
        else $error("narrow beat uses upper bits");
    a_power_off: assert property (
        calm ##0 !cfg_out.power_on |-> !dout_valid_out && !timing_strobe_out)
        else $error("activity while powered down");
endmodule
bind afescr_regs afescr_regs_monitor u_mon (.*);
`default_nettype wire

// *** afescr_regs_test.sv ***
/*
 * Self-checking bench for the setup register bank with a host model.
 * Assumes the checker is bound to the design by its own file.
 */
`timescale 1ns/10ps
`default_nettype none
module afescr_regs_test;
    import afescr_pkg::*;
    typedef struct packed {logic wr; logic [5:0] a; logic [7:0] d; logic [7:0] e;} afescr_row_t;
    logic clock_in, rst_in = 1'b1, ce_in = 1'b1, sample_strobe_pin_in = 1'b0;
    logic second_timing_mode_in = 1'b0, conv_valid_in = 1'b0;
    logic [15:0] conv_data_in = 16'h0000;
    wire logic ser_clk_in, ser_data_in, ser_enable_in;
    logic ser_data_out, ser_data_oe_out, timing_strobe_out, offset_pos_fs_out;
    logic offset_neg_fs_out, clamp_ref_dac_en_out, clamp_ref_oe_out, dout_valid_out;
    logic [3:0] lamp_test_field_out, latency_mclk_out, dout_out;
    afescr_cfg_t cfg_out;
    logic [7:0] q;
    int n_fail = 0;
    int compares = 0;
    afescr_row_t rows [12] = '{
        {1'h0, 6'h01, 8'h00, 8'h03},
        {1'h0, 6'h02, 8'h00, 8'h00},
        {1'h1, 6'h01, 8'h83, 8'h83},
        {1'h1, 6'h24, 8'hFF, 8'h3C},
        {1'h1, 6'h27, 8'hFF, 8'h2A},
        {1'h1, 6'h02, 8'hDF, 8'hDF},
        {1'h1, 6'h01, 8'h7B, 8'h7B},
        {1'h1, 6'h24, 8'h00, 8'h00},
        {1'h1, 6'h01, 8'hA3, 8'hA3},
        {1'h0, 6'h24, 8'h00, 8'h3C},
        {1'h1, 6'h3F, 8'h55, 8'h00},
        {1'h1, 6'h01, 8'h1B, 8'h1B}};
    afescr_regs u_dut (.*);
    afescr_host_model u_host (.clock_in(clock_in), .sdo_in(ser_data_out),
        .soe_in(ser_data_oe_out), .sclk_out(ser_clk_in), .sdata_out(ser_data_in),
        .sen_out(ser_enable_in));
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic strobe(input logic v, input int n);
        int c;
        c = 0;
        sample_strobe_pin_in = v;
        repeat (12) begin
            @(negedge clock_in);
            c += int'(timing_strobe_out === 1'b1);
        end
        chk("strobe pulses", 16'(n), 16'(c));
    endtask
    task automatic word(input logic [15:0] d, input logic [15:0] e, input int nb);
        logic [15:0] acc;
        int b;
        acc = 16'h0000;
        b = 0;
        conv_data_in = d;
        conv_valid_in = 1'b1;
        @(negedge clock_in);
        conv_valid_in = 1'b0;
        repeat (40) begin
            @(negedge clock_in);
            if (dout_valid_out === 1'b1) begin
                acc = (nb == 8) ? {acc[13:0], dout_out[1:0]} : {acc[11:0], dout_out};
                b++;
            end
        end
        chk("beats", 16'(nb), 16'(b));
        chk("word", e, acc);
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (3) @(negedge clock_in);
        rst_in = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) u_host.xfer(1'b0, rows[i].a, rows[i].d, q);
            u_host.xfer(1'b1, rows[i].a, 8'h00, q);
            chk("readback", 16'(rows[i].e), 16'(q));
        end
        chk("cfg", 16'h3A7F, 16'(cfg_out));
        chk("latency", 16'h0006, 16'(latency_mclk_out));
        chk("lamp", 16'h000F, 16'(lamp_test_field_out));
        strobe(1'b1, 1);
        strobe(1'b0, 0);
        u_host.xfer(1'b0, 6'h02, 8'h5E, q);
        second_timing_mode_in = 1'b1;
        strobe(1'b1, 0);
        strobe(1'b0, 1);
        chk("latency", 16'h0003, 16'(latency_mclk_out));
        word(16'hC3A5, 16'h3C5A, 8);
        u_host.xfer(1'b0, 6'h02, 8'h00, q);
        word(16'h5A0F, 16'h5A0F, 4);
        u_host.xfer(1'b0, 6'h01, 8'h03, q);
        sample_strobe_pin_in = 1'b1;
        repeat (8) @(negedge clock_in);
        chk("raw strobe", 16'h0001, 16'(timing_strobe_out));
        u_host.xfer(1'b0, 6'h01, 8'h02, q);
        chk("strobe off", 16'h0000, 16'(timing_strobe_out));
        rst_in = 1'b1;
        repeat (3) @(negedge clock_in);
        rst_in = 1'b0;
        u_host.xfer(1'b1, 6'h01, 8'h00, q);
        chk("reset first", 16'h0003, 16'(q));
        u_host.xfer(1'b1, 6'h02, 8'h00, q);
        chk("reset second", 16'h0000, 16'(q));
        end_sim();
    end
endmodule
`default_nettype wire
